// *** ewu_params.svh ***
// Constants of the event-wait unit: event indices, register offsets and reset values.
`ifndef EWU_PARAMS_SVH
`define EWU_PARAMS_SVH

`define EWU_NUM_EVT      12
`define EWU_EVT_W        4
`define EWU_CFG_W        9
`define EWU_NUM_SLOT     4
`define EWU_DATA_W       32
`define EWU_ADDR_W       8

`define EWU_EVT_ATTN     4'h0
`define EWU_EVT_CT1      4'h1
`define EWU_EVT_CT2      4'h2
`define EWU_EVT_CT3      4'h3
`define EWU_EVT_WRAP     4'h4
`define EWU_EVT_INT      4'h5
`define EWU_EVT_PIN      4'h6
`define EWU_EVT_CUST1    4'h7
`define EWU_EVT_STREAM   4'hB

`define EWU_REG_STATUS   8'h00
`define EWU_REG_MASK     8'h04
`define EWU_REG_FLAGS    8'h08
`define EWU_REG_COUNTER  8'h0C

`define EWU_ST_TIMEOUT   0
`define EWU_ST_EVENT     1
`define EWU_ST_W         2

`define EWU_RST_CFG      9'h000
`define EWU_RST_WORD     32'h0000_0000
`define EWU_RST_ST       2'h0

`endif

// *** ewu_pkg.sv ***
// Types shared by the event-wait unit modules.
package ewu_pkg;
    typedef enum logic [2:0] {
        EWU_OP_SETSE,
        EWU_OP_SETPAT,
        EWU_OP_QPREFIX,
        EWU_OP_WAIT,
        EWU_OP_POLL,
        EWU_OP_OTHER
    } ewu_op_t;

    typedef enum logic [1:0] {
        EWU_S_IDLE,
        EWU_S_WAIT
    } ewu_state_t;
endpackage

// *** ewu_flag_bank.sv ***
// Sticky event flags of the event-wait unit, one bit per event source.
`timescale 1ns/1ns
`default_nettype none
module ewu_flag_bank #(
    parameter int N = 12
) (
    input  wire logic         clk_sys_i,
    input  wire logic         rst_i,
    input  wire logic [N-1:0] set_i,
    input  wire logic [N-1:0] clr_i,
    output logic      [N-1:0] flags_o
);
    typedef struct packed {
        logic [N-1:0] flags;
    } ewu_bank_t;

    ewu_bank_t s_q;
    ewu_bank_t s_d;

    // A set landing in the same cycle as its clear wins, so no event is lost.
    always_comb begin
        s_d = s_q;
        s_d.flags = (s_q.flags & ~clr_i) | set_i;
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign flags_o = s_q.flags;
endmodule
`default_nettype wire

// *** ewu_top.sv ***
// Event-wait unit: event slots, wait and poll operations, timeout and register port.
//
// Notes on behaviour
// RL1 - A slot configure operation loads bits 8:0 of the destination operand and takes two clocks.
// RL2 - A wait stalls until the named event flag is set and then clears that flag.
// RL3 - A queue prefix directly before a wait arms a system-counter timeout, otherwise none.
// RL4 - A finished wait writes the timeout indication to carry, zero or both as selected.
// RL5 - A wait takes at least two clocks and lasts while the flag is clear and no timeout occurs.
// RL6 - Timeout is the system counter reaching the prefixed value and leaves the flag untouched.
// RL7 - A poll copies the event flag to carry and/or zero and clears it in two clocks.
// RL8 - The pin pattern takes mask and match, carry picks the port and zero picks equal or not.
`timescale 1ns/1ns
`default_nettype none
`include "ewu_params.svh"
module ewu_top
    import ewu_pkg::*;
(
    input  wire logic                        clk_sys_i,
    input  wire logic                        rst_i,
    input  wire logic                        op_valid_i,
    input  wire ewu_pkg::ewu_op_t            op_code_i,
    input  wire logic [3:0]                  op_event_i,
    input  wire logic [31:0]                 op_d_i,
    input  wire logic [31:0]                 op_s_i,
    input  wire logic                        op_c_sel_i,
    input  wire logic                        op_z_sel_i,
    input  wire logic                        op_c_i,
    input  wire logic                        op_z_i,
    input  wire logic [11:0]                 event_pulse_i,
    input  wire logic [31:0]                 port_lo_i,
    input  wire logic [31:0]                 port_hi_i,
    input  wire logic [7:0]                  reg_addr_i,
    input  wire logic [31:0]                 reg_wdata_i,
    input  wire logic                        reg_we_i,
    input  wire logic                        reg_re_i,
    output logic      [31:0]                 reg_rdata_o,
    output logic                             busy_o,
    output logic                             done_o,
    output logic                             c_we_o,
    output logic                             z_we_o,
    output logic                             flag_val_o,
    output logic      [3:0][8:0]             slot_cfg_o,
    output logic      [31:0]                 system_counter_o,
    output logic                             irq_o
);
    import ewu_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        ewu_state_t                 state;
        logic [3:0]                 wait_evt;
        logic                       c_sel;
        logic                       z_sel;
        logic                       to_en;
        logic [31:0]                to_val;
        logic [31:0]                q_val;
        logic                       q_armed;
        logic [31:0]                system_counter;
        logic [3:0][8:0]            slot_cfg;
        logic [31:0]                pat_mask;
        logic [31:0]                pat_match;
        logic                       pat_hi;
        logic                       pat_ne;
        logic                       pat_prev;
        logic [1:0]                 status;
        logic [1:0]                 mask;
        logic [31:0]                rdata;
        logic                       irq;
        logic                       done;
        logic                       c_we;
        logic                       z_we;
        logic                       res;
    } ewu_state_all_t;

    ewu_state_all_t s_q;
    ewu_state_all_t s_d;

    logic [11:0] flags;
    logic [11:0] flag_set;
    logic [11:0] flag_clr;
    logic        accept;
    logic        pat_now;
    logic        evt_hit;
    logic        to_hit;
    logic [31:0] pat_port;
    logic [1:0]  st_set;

    // ------------------------------------------------------------
    // Event flags
    // ------------------------------------------------------------
    ewu_flag_bank #(
        .N (`EWU_NUM_EVT)
    ) u_flags (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .set_i     (flag_set),
        .clr_i     (flag_clr),
        .flags_o   (flags)
    );

    assign accept   = op_valid_i && (s_q.state == EWU_S_IDLE);
    assign pat_port = s_q.pat_hi ? port_hi_i : port_lo_i;
    assign pat_now  = ((pat_port & s_q.pat_mask) == s_q.pat_match) ^ s_q.pat_ne; // RL8
    assign evt_hit  = flags[s_q.wait_evt];
    assign to_hit   = s_q.to_en && (s_q.system_counter == s_q.to_val); // RL6

    always_comb begin
        flag_set = event_pulse_i;
        flag_set[`EWU_EVT_PIN] = event_pulse_i[`EWU_EVT_PIN] || (pat_now && !s_q.pat_prev); // RL8
        flag_clr = '0;
        if (accept && op_code_i == EWU_OP_POLL) begin
            flag_clr[op_event_i] = 1'b1; // RL7
        end
        if (s_q.state == EWU_S_WAIT && evt_hit) begin
            flag_clr[s_q.wait_evt] = 1'b1; // RL2
        end
    end

    // ------------------------------------------------------------
    // Operation sequencing and register port
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        st_set = '0;
        s_d.system_counter = s_q.system_counter + 32'h0000_0001;
        s_d.pat_prev = pat_now;
        s_d.done = 1'b0;
        s_d.c_we = 1'b0;
        s_d.z_we = 1'b0;
        s_d.res = 1'b0;
        if (accept) begin
            // Any operation other than the prefix itself uses up the prefix.
            s_d.q_armed = 1'b0;
            case (op_code_i)
                EWU_OP_SETSE: begin
                    s_d.slot_cfg[op_event_i[1:0]] = op_d_i[8:0]; // RL1
                    s_d.done = 1'b1; // RL1
                end
                EWU_OP_SETPAT: begin
                    s_d.pat_mask = op_d_i; // RL8
                    s_d.pat_match = op_s_i;
                    s_d.pat_hi = op_c_i; // RL8
                    s_d.pat_ne = op_z_i; // RL8
                    s_d.done = 1'b1;
                end
                EWU_OP_QPREFIX: begin
                    s_d.q_val = op_d_i;
                    s_d.q_armed = 1'b1; // RL3
                    s_d.done = 1'b1;
                end
                EWU_OP_WAIT: begin
                    s_d.state = EWU_S_WAIT; // RL5
                    s_d.wait_evt = op_event_i;
                    s_d.c_sel = op_c_sel_i;
                    s_d.z_sel = op_z_sel_i;
                    s_d.to_en = s_q.q_armed; // RL3
                    s_d.to_val = s_q.q_val;
                end
                EWU_OP_POLL: begin
                    s_d.done = 1'b1;
                    s_d.res = flags[op_event_i]; // RL7
                    s_d.c_we = op_c_sel_i; // RL7
                    s_d.z_we = op_z_sel_i; // RL7
                end
                default: begin
                    s_d.done = 1'b1;
                end
            endcase
        end
        // The flag wins over a timeout that falls in the same cycle, since the event is real.
        if (s_q.state == EWU_S_WAIT && (evt_hit || to_hit)) begin // RL5
            s_d.state = EWU_S_IDLE;
            s_d.done = 1'b1;
            s_d.res = !evt_hit; // RL4
            s_d.c_we = s_q.c_sel; // RL4
            s_d.z_we = s_q.z_sel; // RL4
            st_set[`EWU_ST_TIMEOUT] = !evt_hit;
            st_set[`EWU_ST_EVENT] = evt_hit;
        end
        s_d.rdata = `EWU_RST_WORD;
        if (reg_re_i) begin
            case (reg_addr_i)
                `EWU_REG_STATUS:  s_d.rdata = {30'h0000_0000, s_q.status};
                `EWU_REG_MASK:    s_d.rdata = {30'h0000_0000, s_q.mask};
                `EWU_REG_FLAGS:   s_d.rdata = {20'h0_0000, flags};
                `EWU_REG_COUNTER: s_d.rdata = s_q.system_counter;
                default:          s_d.rdata = `EWU_RST_WORD;
            endcase
        end
        s_d.status = s_q.status;
        if (reg_we_i && reg_addr_i == `EWU_REG_STATUS) begin
            s_d.status = s_q.status & ~reg_wdata_i[1:0];
        end
        // Setting after the write-one-to-clear keeps a same-cycle event.
        s_d.status = s_d.status | st_set;
        if (reg_we_i && reg_addr_i == `EWU_REG_MASK) begin
            s_d.mask = reg_wdata_i[1:0];
        end
        s_d.irq = |(s_d.status & s_d.mask);
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.state <= EWU_S_IDLE;
            // The reset pattern has no mask bits and always matches, so the detector
            // starts high and leaving reset does not raise a false pin match.
            s_q.pat_prev <= 1'b1; // RL8
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata_o      = s_q.rdata;
    assign busy_o           = (s_q.state == EWU_S_WAIT);
    assign done_o           = s_q.done;
    assign c_we_o           = s_q.c_we;
    assign z_we_o           = s_q.z_we;
    assign flag_val_o       = s_q.res;
    assign slot_cfg_o       = s_q.slot_cfg;
    assign system_counter_o = s_q.system_counter;
    assign irq_o            = s_q.irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    sequence seq_issue_wait;
        accept && op_code_i == EWU_OP_WAIT;
    endsequence

    sequence seq_event_end;
        busy_o && evt_hit;
    endsequence

    chk_cfg_load: assert property ( // RL1
        accept && op_code_i == EWU_OP_SETSE && op_event_i[1:0] == 2'h0
        |=> done_o && slot_cfg_o[0] == $past(op_d_i[8:0]) && !busy_o)
        else $error("slot configure did not load in two clocks");

    chk_wait_min: assert property ( // RL5
        seq_issue_wait |=> busy_o && !done_o)
        else $error("wait finished before its second clock");

    chk_wait_event: assert property ( // RL2
        seq_event_end |=> done_o && !flag_val_o && !busy_o)
        else $error("wait did not end on its event");

    chk_event_clear: assert property ( // RL2
        seq_event_end ##0 !event_pulse_i[s_q.wait_evt] && s_q.wait_evt != `EWU_EVT_PIN
        |=> !flags[$past(s_q.wait_evt)])
        else $error("awaited flag not cleared");

    chk_timeout_end: assert property ( // RL6
        busy_o && !evt_hit && to_hit |=> done_o && flag_val_o && !busy_o)
        else $error("timeout did not end the wait");

    chk_no_prefix: assert property ( // RL3
        seq_issue_wait ##0 !s_q.q_armed |=> !s_q.to_en [*2])
        else $error("wait without prefix armed a timeout");

    chk_wait_flags: assert property ( // RL4
        busy_o && (evt_hit || to_hit)
        |=> c_we_o == $past(s_q.c_sel) && z_we_o == $past(s_q.z_sel))
        else $error("wait wrote the wrong flags");

    chk_poll_copy: assert property ( // RL7
        accept && op_code_i == EWU_OP_POLL
        |=> done_o && !busy_o && flag_val_o == $past(flags[op_event_i])
            && c_we_o == $past(op_c_sel_i) && z_we_o == $past(op_z_sel_i))
        else $error("poll result wrong");

    chk_pat_event: assert property ( // RL8
        pat_now && !s_q.pat_prev && !(accept && op_code_i == EWU_OP_POLL)
        && !(busy_o && evt_hit) |=> flags[`EWU_EVT_PIN])
        else $error("pin pattern match did not raise its flag");

    sequence seq_timeout_end;
        busy_o && to_hit && !evt_hit;
    endsequence

    chk_wait_hold: assert property ( // RL5
        busy_o && !evt_hit && !to_hit |=> busy_o && !done_o)
        else $error("wait ended with no event and no timeout");

    chk_prefix_arm: assert property ( // RL3
        seq_issue_wait ##0 s_q.q_armed |=> s_q.to_en && s_q.to_val == $past(s_q.q_val))
        else $error("prefixed wait did not arm its timeout");

    chk_timeout_status: assert property ( // RL6
        seq_timeout_end |=> s_q.status[`EWU_ST_TIMEOUT] && flag_val_o)
        else $error("timeout not recorded in status");

    chk_poll_clear: assert property ( // RL7
        accept && op_code_i == EWU_OP_POLL && op_event_i != `EWU_EVT_PIN
        && !event_pulse_i[op_event_i] |=> !flags[$past(op_event_i)])
        else $error("polled flag not cleared");

    chk_rdata_idle: assert property (
        !reg_re_i |=> reg_rdata_o == `EWU_RST_WORD)
        else $error("read data not zero outside a read");
endmodule
`default_nettype wire

// *** ewu_exec_model.sv ***
// Model of the execution stage that issues operations to the event-wait unit.
`timescale 1ns/1ns
`default_nettype none
module ewu_exec_model (
    input  wire logic        clk_sys_i,
    input  wire logic        busy_i,
    input  wire logic        done_i,
    output logic             op_valid_o,
    output ewu_pkg::ewu_op_t op_code_o,
    output logic [3:0]       op_event_o,
    output logic [31:0]      op_d_o,
    output logic [31:0]      op_s_o,
    output logic             op_c_sel_o,
    output logic             op_z_sel_o,
    output logic             op_c_o,
    output logic             op_z_o
);
    import ewu_pkg::*;
    initial begin
        op_valid_o = 1'b0;
        op_code_o = EWU_OP_OTHER;
        op_event_o = 4'h0;
        op_d_o = 32'h0;
        op_s_o = 32'h0;
        {op_c_sel_o, op_z_sel_o, op_c_o, op_z_o} = 4'h0;
    end
    // Operands are scrambled once taken, so a core that samples late sees garbage.
    task automatic issue(input ewu_op_t c, input logic [3:0] e, input logic [31:0] d, s,
                         input logic [3:0] f, output int lat);
        int n;
        for (n = 0; n < 2000 && busy_i !== 1'b0; n++) @(posedge clk_sys_i);
        @(posedge clk_sys_i);
        op_valid_o <= 1'b1;
        op_code_o <= c;
        op_event_o <= e;
        op_d_o <= d;
        op_s_o <= s;
        {op_c_sel_o, op_z_sel_o, op_c_o, op_z_o} <= f;
        @(posedge clk_sys_i);
        op_valid_o <= 1'b0;
        op_d_o <= ~d;
        op_s_o <= ~s;
        lat = -1;
        for (n = 1; n < 2000 && lat < 0; n++) begin
            @(posedge clk_sys_i);
            if (done_i === 1'b1) lat = n;
        end
    endtask
endmodule
`default_nettype wire

// *** test_ewu_top.sv ***
// Self-checking testbench of the event-wait unit.
`timescale 1ns/1ns
`default_nettype none
`include "ewu_params.svh"
module test_ewu_top;
    import ewu_pkg::*;
    logic clk_sys_i = 1'b0, rst_i = 1'b1, reg_we_i = 1'b0, reg_re_i = 1'b0, rd_p = 1'b0;
    logic op_valid_i, op_c_sel_i, op_z_sel_i, op_c_i, op_z_i, busy_o, done_o, c_we_o, z_we_o;
    logic flag_val_o, irq_o;
    ewu_op_t op_code_i;
    logic [3:0] op_event_i, f, ex;
    logic [31:0] op_d_i, op_s_i, reg_rdata_o, system_counter_o, d;
    logic [31:0] port_lo_i = 32'h0, port_hi_i = 32'h0, reg_wdata_i = 32'h0;
    logic [11:0] event_pulse_i = 12'h000;
    logic [7:0] reg_addr_i = 8'h00;
    logic [3:0][8:0] slot_cfg_o;
    logic [31:0] cyc = 32'h0000_0000;
    int n_fail = 0, checked = 0, lat, i, dly;
    integer seed = 32'h03ec;
    logic [3:0] eq[$];
    logic [31:0] rq[$];

    always #20 clk_sys_i = ~clk_sys_i;

    ewu_top u_ewu_top (.clk_sys_i, .rst_i, .op_valid_i, .op_code_i, .op_event_i, .op_d_i,
        .op_s_i, .op_c_sel_i, .op_z_sel_i, .op_c_i, .op_z_i, .event_pulse_i, .port_lo_i,
        .port_hi_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i, .reg_rdata_o, .busy_o,
        .done_o, .c_we_o, .z_we_o, .flag_val_o, .slot_cfg_o, .system_counter_o, .irq_o);
    ewu_exec_model m_exec (.clk_sys_i, .busy_i(busy_o), .done_i(done_o),
        .op_valid_o(op_valid_i), .op_code_o(op_code_i), .op_event_o(op_event_i),
        .op_d_o(op_d_i), .op_s_o(op_s_i), .op_c_sel_o(op_c_sel_i), .op_z_sel_o(op_z_sel_i),
        .op_c_o(op_c_i), .op_z_o(op_z_i));

    // ----------------------------------------
    // Tasks and result monitor
    // ----------------------------------------
    task automatic check(input logic [39:0] got, input logic [39:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_we_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_we_i <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
        rq.push_back(exp);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_re_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_re_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    // The note holds {care, result bit, carry write, zero write} of the next finished op.
    task automatic op(input ewu_op_t c, input logic [3:0] e, input logic [31:0] dd, s,
                      input logic [3:0] fl, input logic [3:0] exp);
        eq.push_back(exp);
        m_exec.issue(c, e, dd, s, fl, lat);
        if (lat < 0) begin
            n_fail++;
            close_out();
        end
    endtask
    task automatic pulse(input int e, input int w);
        repeat (w) @(posedge clk_sys_i);
        event_pulse_i <= 12'h001 << e;
        @(posedge clk_sys_i);
        event_pulse_i <= 12'h000;
    endtask
    task automatic settle(input int w);
        repeat (w) @(posedge clk_sys_i);
    endtask
    always @(posedge clk_sys_i) begin
        rd_p <= reg_re_i;
        cyc <= rst_i ? 32'h0000_0000 : cyc + 32'h0000_0001;
        if (rd_p) check(reg_rdata_o, rq.pop_front());
        if (done_o === 1'b1) begin
            ex = (eq.size() > 0) ? eq.pop_front() : 4'hF;
            if (ex[3]) check({flag_val_o, c_we_o, z_we_o}, ex[2:0]);
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        settle(4);
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
        check({busy_o, done_o, irq_o, slot_cfg_o}, 36'h0);
        reg_rd(`EWU_REG_STATUS, 32'h0);
        reg_rd(8'h10, 32'h0);
        reg_wr(`EWU_REG_MASK, 32'h1);
        op(EWU_OP_POLL, 4'h6, 0, 0, 4'h0, 4'h8);
        for (i = 0; i < 4; i++) begin
            d = $random(seed);
            op(EWU_OP_SETSE, 4'(i), d, 0, 4'h0, 4'h0);
            check(lat, 1);
            settle(1);
            check(slot_cfg_o[i], d[8:0]);
        end
        op(EWU_OP_OTHER, 4'h0, 0, 0, 4'h0, 4'h8);
        check(lat, 1);
        for (i = 0; i < 24; i++) begin
            f = {2'(i % 3 + 1), 2'b00};
            if (i % 2 == 0) pulse(i / 2, 0);
            op(EWU_OP_POLL, 4'(i / 2), 0, 0, f, {1'b1, i % 2 == 0, f[3:2]});
            check(lat, 1);
        end
        for (i = 0; i < 12; i++) begin
            f = {2'(i % 3 + 1), 2'b00};
            dly = 2 + ($random(seed) & 7);
            fork
                op(EWU_OP_WAIT, 4'(i), 0, 0, f, {2'b10, f[3:2]});
                pulse(i, dly);
            join
            check(lat >= 2 && lat <= dly + 4, 1);
            reg_rd(`EWU_REG_FLAGS, 32'h0);
        end
        pulse(3, 0);
        op(EWU_OP_WAIT, 4'h3, 0, 0, 4'hC, 4'hB);
        check(lat, 2);
        check(irq_o, 0);
        op(EWU_OP_QPREFIX, 4'h0, system_counter_o + 32'd20, 0, 4'h0, 4'h0);
        op(EWU_OP_WAIT, 4'h5, 0, 0, 4'hC, 4'hF);
        check(lat >= 12 && lat <= 22, 1);
        check(system_counter_o, cyc);
        reg_rd(`EWU_REG_COUNTER, cyc + 32'd2);
        op(EWU_OP_QPREFIX, 4'h0, system_counter_o + 32'd16, 0, 4'h0, 4'h0);
        op(EWU_OP_POLL, 4'h1, 0, 0, 4'h0, 4'h8);
        fork
            op(EWU_OP_WAIT, 4'h1, 0, 0, 4'h8, 4'hA);
            pulse(1, 30);
        join
        check(lat >= 25, 1);
        // Status and mask: the event-ended bit was set long ago but stays masked until mask bit 1 is written below.
        check(irq_o, 1);
        reg_rd(`EWU_REG_STATUS, 32'h3);
        reg_wr(`EWU_REG_STATUS, 32'h1);
        settle(2);
        check(irq_o, 0);
        reg_wr(`EWU_REG_MASK, 32'h2);
        reg_rd(`EWU_REG_MASK, 32'h2);
        settle(2);
        check(irq_o, 1);
        reg_wr(`EWU_REG_STATUS, 32'h2);
        reg_rd(`EWU_REG_STATUS, 32'h0);
        check(irq_o, 0);
        port_hi_i <= 32'h0000_005A;
        op(EWU_OP_SETPAT, 4'h0, 32'h0000_00FF, 32'h0000_005A, 4'h0, 4'h0);
        fork
            op(EWU_OP_WAIT, 4'h6, 0, 0, 4'h4, 4'h9);
            begin
                settle(5);
                check(busy_o, 1);
                port_lo_i <= 32'h1234_565A;
            end
        join
        op(EWU_OP_SETPAT, 4'h0, 32'h0000_00FF, 32'h0000_005A, 4'h3, 4'h0);
        fork
            op(EWU_OP_WAIT, 4'h6, 0, 0, 4'h8, 4'hA);
            begin
                settle(5);
                port_hi_i <= $random(seed) & 32'hFFFF_FF00 | 32'h33;
            end
        join
        close_out();
    end
endmodule
`default_nettype wire
